// file: rtl/exc_pkg.sv
// Summary of operation
// - Each exception fetches from its own fixed vector; both aborts enter abort mode, trap and address exception supervisor.
// - Vector 0x14 serves the address exception, live only in 26-bit program space.
// - Coinciding exceptions: reset, data abort, fast, normal, prefetch, undefined or trap.
// - Undefined instruction and software trap are never raised together.
// - Data abort with unmasked fast interrupt enters abort, then fast vector at once.
// - Reset held low abandons the instruction and idles on incrementing word addresses.
// - At reset end, one or two accesses from the address then reached.
// - Reset release copies program counter and status into supervisor link and saved status.
// - Reset release sets mode to supervisor 10011 and both interrupt masks.
// - After reset release, fetch starts at address zero.
// - Reset completion disables translation and flushes the lookaside buffer.
// - Reset completion disables alignment checks; cache and write buffer off and flushed.
// - Reset completion leaves 26-bit data and address, early abort, little endian.
// - Entry writes the mode code and sets the interrupt mask, fast mask for fast entry.
// - Aborts save address plus 4 or plus 8 in abort link, status in abort saved.
// - Interrupt pins are synchronised and sampled at instruction end when unmasked.
package exc_pkg;

    // ------------------------------------------------------------
    // Vector addresses.
    // ------------------------------------------------------------
    localparam logic [31:0] VEC_RESET = 32'h0000_0000;
    localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
    localparam logic [31:0] VEC_TRAP  = 32'h0000_0008;
    localparam logic [31:0] VEC_PABT  = 32'h0000_000c;
    localparam logic [31:0] VEC_DABT  = 32'h0000_0010;
    localparam logic [31:0] VEC_ADDR  = 32'h0000_0014;
    localparam logic [31:0] VEC_IRQ   = 32'h0000_0018;
    localparam logic [31:0] VEC_FIQ   = 32'h0000_001c;

    // ------------------------------------------------------------
    // Mode codes and status word layout.
    // ------------------------------------------------------------
    localparam logic [4:0]  MODE_FIQ  = 5'h11;
    localparam logic [4:0]  MODE_IRQ  = 5'h12;
    localparam logic [4:0]  MODE_SVC  = 5'h13;
    localparam logic [4:0]  MODE_ABT  = 5'h17;
    localparam logic [4:0]  MODE_UND  = 5'h1b;
    localparam int          BIT_F     = 6;
    localparam int          BIT_I     = 7;
    localparam logic [31:0] STATUS_RST = 32'h0000_00d3;

    // ------------------------------------------------------------
    // Offsets and counts.
    // ------------------------------------------------------------
    localparam logic [31:0] PABT_OFS  = 32'h0000_0004;
    localparam logic [31:0] DABT_OFS  = 32'h0000_0008;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    localparam logic [31:0] BUS_RST   = 32'h0000_0000;
    localparam int          RST_ACC_DEF = 2;
    localparam logic [2:0]  SYNC_RST  = 3'h7;

    // ------------------------------------------------------------
    // Types.
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] vector;
        logic [4:0]  mode;
    } entry_t;

    typedef struct packed {
        logic mmuOn;
        logic alignOn;
        logic cacheOn;
        logic wbOn;
        logic prog32;
        logic data32;
        logic lateAbort;
        logic bigEnd;
    } cfg_t;

    localparam cfg_t CFG_RST = 8'h00;

    typedef enum logic [2:0] {
        EXC_NONE, EXC_DABT, EXC_FIQ, EXC_IRQ,
        EXC_PABT, EXC_UNDEF, EXC_TRAP, EXC_ADDR
    } exc_t;

    typedef enum logic [1:0] {
        ST_RUN, ST_RST_IDLE, ST_RST_ACC, ST_RST_ENTRY
    } state_t;

endpackage

// file: rtl/sync_two_ff.sv
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff #(
    parameter int         W   = 3,
    parameter logic [W-1:0] RST = '1
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         resetn,
    // Levels in and out.
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;

    // The first stage feeds only the second one.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= RST;
            dout   <= RST;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule
`default_nettype wire

// file: rtl/exc_priority.sv
`timescale 1ns/1ps
`default_nettype none
module exc_priority (
    // Pending requests.
    input  wire logic dataAbort,
    input  wire logic fiqReq,
    input  wire logic irqReq,
    input  wire logic prefetchAbort,
    input  wire logic undefInstr,
    input  wire logic swTrap,
    input  wire logic addrReq,
    // Winner.
    output exc_pkg::exc_t sel
);
    // Fixed order; undefined wins over trap so a bad decode never yields both.
    assign sel = dataAbort     ? exc_pkg::EXC_DABT  :
                 fiqReq        ? exc_pkg::EXC_FIQ   :
                 irqReq        ? exc_pkg::EXC_IRQ   :
                 prefetchAbort ? exc_pkg::EXC_PABT  :
                 undefInstr    ? exc_pkg::EXC_UNDEF :
                 swTrap        ? exc_pkg::EXC_TRAP  :
                 addrReq       ? exc_pkg::EXC_ADDR  :
                                 exc_pkg::EXC_NONE;
endmodule
`default_nettype wire

// file: rtl/exception_vector_reset_unit.sv
`timescale 1ns/1ps
`default_nettype none
module exception_vector_reset_unit #(
    parameter int RESET_ACCESSES = exc_pkg::RST_ACC_DEF
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        resetn,
    // Pins from system logic.
    input  wire logic        chip_reset_low,
    input  wire logic        fast_irq_in_low,
    input  wire logic        normal_irq_in_low,
    // Core events.
    input  wire logic        instrEnd,
    input  wire logic [31:0] instrAddr,
    input  wire logic        dataAbort,
    input  wire logic        prefetchAbort,
    input  wire logic        undefInstr,
    input  wire logic        swTrap,
    input  wire logic        addrExc,
    // Core state updates.
    input  wire logic        statusWe,
    input  wire logic [31:0] statusIn,
    input  wire logic [31:0] pcIn,
    input  wire logic        cfgWe,
    input  wire exc_pkg::cfg_t cfgIn,
    // Entry to fetch and status logic.
    output logic             entryValid,
    output exc_pkg::entry_t  entry,
    output logic [31:0]      current_status_word,
    output logic [31:0]      supervisor_link_reg,
    output logic [31:0]      supervisor_saved_status,
    output logic [31:0]      abort_link_reg,
    output logic [31:0]      abort_saved_status,
    // Reset bus activity.
    output logic [31:0]      busAddr,
    output logic             busIdle,
    output logic             busAccess,
    // Memory system configuration.
    output exc_pkg::cfg_t    cfg,
    output logic             tlbFlush,
    output logic             cacheFlush,
    output logic             wbFlush
);

    // ------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------
    logic [2:0] pinSync;
    wire        fiqLow = pinSync[0];
    wire        irqLow = pinSync[1];
    wire        rstLow = !pinSync[2];  // High while the reset pin is held low.

    // Two stages; interrupts react two clocks later than raw.
    sync_two_ff #(
        .W   (3),
        .RST (exc_pkg::SYNC_RST)
    ) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    ({chip_reset_low, normal_irq_in_low, fast_irq_in_low}),
        .dout   (pinSync)
    );

    // ------------------------------------------------------------
    // Request qualification.
    // ------------------------------------------------------------
    exc_pkg::state_t state_r;
    exc_pkg::state_t state_nxt;
    logic            fiqChain_r;
    exc_pkg::exc_t   sel;
    exc_pkg::exc_t   kind;
    logic [7:0]      accCnt_r;

    // Levels only count when their mask bit is clear.
    wire fMask   = current_status_word[exc_pkg::BIT_F];
    wire iMask   = current_status_word[exc_pkg::BIT_I];
    wire fiqReq  = !fiqLow && !fMask;
    wire irqReq  = !irqLow && !iMask;
    wire addrReq = addrExc && !cfg.prog32;
    wire running = (state_r == exc_pkg::ST_RUN);

    exc_priority u_prio (
        .dataAbort     (dataAbort),
        .fiqReq        (fiqReq),
        .irqReq        (irqReq),
        .prefetchAbort (prefetchAbort),
        .undefInstr    (undefInstr),
        .swTrap        (swTrap),
        .addrReq       (addrReq),
        .sel           (sel)
    );

    // A chained fast entry overrides the normal sample point.
    assign kind = fiqChain_r ? exc_pkg::EXC_FIQ :
                  instrEnd   ? sel : exc_pkg::EXC_NONE;

    wire take      = running && !rstLow && (kind != exc_pkg::EXC_NONE);
    wire takeDabt  = take && (kind == exc_pkg::EXC_DABT);
    wire takePabt  = take && (kind == exc_pkg::EXC_PABT);
    wire chainNext = takeDabt && !fiqLow && !fMask;

    // ------------------------------------------------------------
    // Vector and mode selection.
    // ------------------------------------------------------------
    logic [31:0] entVec;
    logic [4:0]  entMode;

    // One table for every synchronous entry; reset has its own path.
    always_comb begin
        case (kind)
            exc_pkg::EXC_DABT: begin
                entVec  = exc_pkg::VEC_DABT;
                entMode = exc_pkg::MODE_ABT;
            end
            exc_pkg::EXC_FIQ: begin
                entVec  = exc_pkg::VEC_FIQ;
                entMode = exc_pkg::MODE_FIQ;
            end
            exc_pkg::EXC_IRQ: begin
                entVec  = exc_pkg::VEC_IRQ;
                entMode = exc_pkg::MODE_IRQ;
            end
            exc_pkg::EXC_PABT: begin
                entVec  = exc_pkg::VEC_PABT;
                entMode = exc_pkg::MODE_ABT;
            end
            exc_pkg::EXC_UNDEF: begin
                entVec  = exc_pkg::VEC_UNDEF;
                entMode = exc_pkg::MODE_UND;
            end
            exc_pkg::EXC_TRAP: begin
                entVec  = exc_pkg::VEC_TRAP;
                entMode = exc_pkg::MODE_SVC;
            end
            exc_pkg::EXC_ADDR: begin
                entVec  = exc_pkg::VEC_ADDR;
                entMode = exc_pkg::MODE_SVC;
            end
            default: begin
                entVec  = exc_pkg::VEC_RESET;
                entMode = exc_pkg::MODE_SVC;
            end
        endcase
    end

    // Status after entry: new mode, I set, F also for fast entry.
    logic [31:0] entStatus;
    always_comb begin
        entStatus = current_status_word;
        entStatus[4:0] = entMode;
        entStatus[exc_pkg::BIT_I] = 1'b1;
        if (kind == exc_pkg::EXC_FIQ) begin
            entStatus[exc_pkg::BIT_F] = 1'b1;
        end
    end

    // Reset status keeps the other bits but forces mode and masks.
    logic [31:0] rstStatus;
    always_comb begin
        rstStatus = current_status_word;
        rstStatus[4:0] = exc_pkg::MODE_SVC;
        rstStatus[exc_pkg::BIT_I] = 1'b1;
        rstStatus[exc_pkg::BIT_F] = 1'b1;
    end

    // ------------------------------------------------------------
    // Reset sequencer.
    // ------------------------------------------------------------
    wire accDone = (accCnt_r == 8'h00);
    wire inEntry = (state_r == exc_pkg::ST_RST_ENTRY);

    // Reset low abandons whatever is in flight, from any state.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            exc_pkg::ST_RUN: begin
                state_nxt = exc_pkg::ST_RUN;
            end
            exc_pkg::ST_RST_IDLE: begin
                if (!rstLow) begin
                    state_nxt = exc_pkg::ST_RST_ACC;
                end
            end
            exc_pkg::ST_RST_ACC: begin
                if (accDone) begin
                    state_nxt = exc_pkg::ST_RST_ENTRY;
                end
            end
            exc_pkg::ST_RST_ENTRY: begin
                state_nxt = exc_pkg::ST_RUN;
            end
            default: begin
                state_nxt = exc_pkg::ST_RST_IDLE;
            end
        endcase
        if (rstLow) begin
            state_nxt = exc_pkg::ST_RST_IDLE;
        end
    end

    // Power-up goes through the same sequence as a pin reset.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= exc_pkg::ST_RST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Accesses left before the entry; counted in the access state.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            accCnt_r <= 8'h00;
        end else if (state_nxt == exc_pkg::ST_RST_ACC && !(state_r == exc_pkg::ST_RST_ACC)) begin
            accCnt_r <= 8'(RESET_ACCESSES - 1);
        end else if (!accDone) begin
            accCnt_r <= accCnt_r - 8'h01;
        end
    end

    // Idle cycles walk word addresses; accesses hold the last one.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busAddr   <= exc_pkg::BUS_RST;
            busIdle   <= 1'b0;
            busAccess <= 1'b0;
        end else begin
            busIdle   <= (state_nxt == exc_pkg::ST_RST_IDLE);
            busAccess <= (state_nxt == exc_pkg::ST_RST_ACC);
            if (state_r == exc_pkg::ST_RST_IDLE && rstLow) begin
                busAddr <= busAddr + exc_pkg::WORD_STEP;
            end
        end
    end

    // ------------------------------------------------------------
    // Entry output, registered one cycle after selection.
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            entryValid <= 1'b0;
            entry      <= '0;
            fiqChain_r <= 1'b0;
        end else begin
            entryValid <= take || inEntry;
            fiqChain_r <= chainNext;
            if (inEntry) begin
                entry.vector <= exc_pkg::VEC_RESET;
                entry.mode   <= exc_pkg::MODE_SVC;
            end else if (take) begin
                entry.vector <= entVec;
                entry.mode   <= entMode;
            end
        end
    end

    // ------------------------------------------------------------
    // Status word and banked copies.
    // ------------------------------------------------------------
    // Hardware entry outranks a software status write in one cycle.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            current_status_word <= exc_pkg::STATUS_RST;
        end else if (inEntry) begin
            current_status_word <= rstStatus;
        end else if (take) begin
            current_status_word <= entStatus;
        end else if (statusWe) begin
            current_status_word <= statusIn;
        end
    end

    // Copied values have no meaning to software; only the act matters.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            supervisor_link_reg     <= '0;
            supervisor_saved_status <= '0;
        end else if (inEntry) begin
            supervisor_link_reg     <= pcIn;
            supervisor_saved_status <= current_status_word;
        end
    end

    // Abort link points past the faulting instruction for the retry.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            abort_link_reg     <= '0;
            abort_saved_status <= '0;
        end else if (takeDabt || takePabt) begin
            abort_link_reg <= instrAddr + (takeDabt ? exc_pkg::DABT_OFS
                                                    : exc_pkg::PABT_OFS);
            abort_saved_status <= current_status_word;
        end
    end

    // ------------------------------------------------------------
    // Memory system configuration.
    // ------------------------------------------------------------
    // Reset completion forces everything off, flat, 26-bit, little endian.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg        <= exc_pkg::CFG_RST;
            tlbFlush   <= 1'b0;
            cacheFlush <= 1'b0;
            wbFlush    <= 1'b0;
        end else begin
            tlbFlush   <= inEntry;
            cacheFlush <= inEntry;
            wbFlush    <= inEntry;
            if (inEntry) begin
                cfg <= exc_pkg::CFG_RST;
            end else if (cfgWe) begin
                cfg <= cfgIn;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_dabt_vec;
        take && kind == exc_pkg::EXC_DABT |=> entryValid && entry.vector == exc_pkg::VEC_DABT
            && entry.mode == exc_pkg::MODE_ABT;
    endproperty
    a_dabt_vec: assert property (p_dabt_vec) else $error("data abort vector wrong");

    property p_fiq_over_irq;
        running && !rstLow && instrEnd && !fiqChain_r && !dataAbort && fiqReq
            |=> entry.vector == exc_pkg::VEC_FIQ && current_status_word[exc_pkg::BIT_F];
    endproperty
    a_fiq_over_irq: assert property (p_fiq_over_irq) else $error("fast interrupt lost priority");

    property p_chain;
        chainNext |=> entry.vector == exc_pkg::VEC_DABT ##1 entryValid
            && entry.vector == exc_pkg::VEC_FIQ;
    endproperty
    a_chain: assert property (p_chain) else $error("abort then fast entry missing");

    property p_idle_walk;
        state_r == exc_pkg::ST_RST_IDLE && rstLow |=> busAddr == $past(busAddr) + exc_pkg::WORD_STEP;
    endproperty
    a_idle_walk: assert property (p_idle_walk) else $error("idle address not stepping");

    property p_rst_entry;
        inEntry |=> entryValid && entry.vector == exc_pkg::VEC_RESET
            && current_status_word[4:0] == exc_pkg::MODE_SVC
            && current_status_word[exc_pkg::BIT_I] && current_status_word[exc_pkg::BIT_F];
    endproperty
    a_rst_entry: assert property (p_rst_entry) else $error("reset entry state wrong");

    property p_rst_cfg;
        inEntry |=> cfg == exc_pkg::CFG_RST && tlbFlush && cacheFlush && wbFlush;
    endproperty
    a_rst_cfg: assert property (p_rst_cfg) else $error("reset configuration wrong");

    property p_pabt_link;
        takePabt |=> abort_link_reg == $past(instrAddr) + exc_pkg::PABT_OFS
            && abort_saved_status == $past(current_status_word);
    endproperty
    a_pabt_link: assert property (p_pabt_link) else $error("prefetch abort link wrong");

    property p_sync;
        !fast_irq_in_low [*3] |-> !fiqLow;
    endproperty
    a_sync: assert property (p_sync) else $error("fast pin not synchronised");

    property p_addr_slot;
        entryValid && entry.vector == exc_pkg::VEC_ADDR |-> $past(!cfg.prog32);
    endproperty
    a_addr_slot: assert property (p_addr_slot) else $error("address slot used in 32-bit mode");

endmodule
`default_nettype wire

// file: tb/irq_source_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// System logic that owns the reset and interrupt pins.
// ------------------------------------------------------------
module irq_source_model (
    // Requests from the test sequence.
    input  wire logic rstReq,
    input  wire logic fiqReq,
    input  wire logic irqReq,
    // Active-low pins toward the unit.
    output logic      rstPinN,
    output logic      fiqPinN,
    output logic      irqPinN
);
    // Plain levels with no relation to the clock, so the unit's synchronisers are exercised.
    assign rstPinN = ~rstReq;
    assign fiqPinN = ~fiqReq;
    assign irqPinN = ~irqReq;
endmodule
`default_nettype wire

// file: tb/test_exception_vector_reset_unit.sv
`timescale 1ns/1ps
`default_nettype none
module test_exception_vector_reset_unit;
    logic            clk, resetn, rstReq, fiqReq, irqReq, rstPinN, fiqPinN, irqPinN;
    logic            instrEnd, dataAbort, prefetchAbort, undefInstr, swTrap, addrExc;
    logic            statusWe, cfgWe, entryValid, busIdle, busAccess, tlbFlush, cacheFlush, wbFlush;
    logic [31:0]     instrAddr, statusIn, pcIn, status, svcLink, svcSaved, abtLink, abtSaved, busAddr, a;
    exc_pkg::entry_t entry;
    exc_pkg::cfg_t   cfgIn, cfg;
    int              error_cnt, tests_run, accCnt, i;
    logic [4:0]      reqTab [8];
    logic [31:0]     vecTab [8];
    logic [4:0]      modeTab [8];

    irq_source_model i_src (.rstReq(rstReq), .fiqReq(fiqReq), .irqReq(irqReq),
        .rstPinN(rstPinN), .fiqPinN(fiqPinN), .irqPinN(irqPinN));

    exception_vector_reset_unit #(.RESET_ACCESSES(2)) i_dut (.clk(clk), .resetn(resetn),
        .chip_reset_low(rstPinN), .fast_irq_in_low(fiqPinN), .normal_irq_in_low(irqPinN),
        .instrEnd(instrEnd), .instrAddr(instrAddr), .dataAbort(dataAbort),
        .prefetchAbort(prefetchAbort), .undefInstr(undefInstr), .swTrap(swTrap),
        .addrExc(addrExc), .statusWe(statusWe), .statusIn(statusIn), .pcIn(pcIn),
        .cfgWe(cfgWe), .cfgIn(cfgIn), .entryValid(entryValid), .entry(entry),
        .current_status_word(status), .supervisor_link_reg(svcLink),
        .supervisor_saved_status(svcSaved), .abort_link_reg(abtLink),
        .abort_saved_status(abtSaved), .busAddr(busAddr), .busIdle(busIdle),
        .busAccess(busAccess), .cfg(cfg), .tlbFlush(tlbFlush), .cacheFlush(cacheFlush),
        .wbFlush(wbFlush));

    // ------------------------------------------------------------
    // Clock and watchdog.
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // The whole sequence needs under a hundred cycles; two thousand means a hang.
    initial begin
        #(25 * 2000);
        error_cnt++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("mismatches %0d of %0d checks", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Request bits are {data abort, prefetch abort, undefined, trap, address}.
    task automatic fire(input logic [4:0] r);
        @(posedge clk);
        instrEnd <= 1'b1;
        {dataAbort, prefetchAbort, undefInstr, swTrap, addrExc} <= r;
        @(posedge clk);
        instrEnd <= 1'b0;
        {dataAbort, prefetchAbort, undefInstr, swTrap, addrExc} <= 5'h00;
        #1;
    endtask

    task automatic wr_status(input logic [31:0] v);
        @(posedge clk);
        statusWe <= 1'b1;
        statusIn <= v;
        @(posedge clk);
        statusWe <= 1'b0;
    endtask

    // Bounded wait for the reset entry, counting the end-of-reset access cycles.
    task automatic wait_reset_entry();
        accCnt = 0;
        for (int n = 0; n < 30 && entryValid !== 1'b1; n++) begin
            if (busAccess === 1'b1) accCnt++;
            @(posedge clk);
            #1;
        end
        chk(entry, {exc_pkg::VEC_RESET, exc_pkg::MODE_SVC});
        chk(status[7:0], 8'hd3);
        chk(accCnt, 2);
        chk(cfg, exc_pkg::CFG_RST);
        chk({tlbFlush, cacheFlush, wbFlush}, 3'h7);
        chk(svcLink, pcIn);
    endtask

    task automatic take_irq(input logic [31:0] v, input logic [4:0] m);
        repeat (3) @(posedge clk);
        fire(5'h00);
        chk(entry, {v, m});
    endtask

    // ------------------------------------------------------------
    // Test sequence.
    // ------------------------------------------------------------
    initial begin
        {resetn, rstReq, fiqReq, irqReq, instrEnd, statusWe, cfgWe} = 7'h00;
        {dataAbort, prefetchAbort, undefInstr, swTrap, addrExc} = 5'h00;
        {statusIn, cfgIn, error_cnt, tests_run} = '0;
        pcIn = 32'h0000_1234;
        instrAddr = 32'h0000_0100;
        reqTab  = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h1c, 5'h0b, 5'h03};
        vecTab  = '{exc_pkg::VEC_DABT, exc_pkg::VEC_PABT, exc_pkg::VEC_UNDEF, exc_pkg::VEC_TRAP,
                    exc_pkg::VEC_ADDR, exc_pkg::VEC_DABT, exc_pkg::VEC_PABT, exc_pkg::VEC_TRAP};
        modeTab = '{exc_pkg::MODE_ABT, exc_pkg::MODE_ABT, exc_pkg::MODE_UND, exc_pkg::MODE_SVC,
                    exc_pkg::MODE_SVC, exc_pkg::MODE_ABT, exc_pkg::MODE_ABT, exc_pkg::MODE_SVC};
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        chk({busIdle, busAccess}, 2'h1);
        wait_reset_entry();
        // Status before each entry: masks set, mode of the previous entry.
        a = 32'h0000_00d3;
        // Single exceptions, then coinciding ones resolved by priority.
        for (i = 0; i < 8; i++) begin
            fire(reqTab[i]);
            chk(entryValid, 1'b1);
            chk(entry, {vecTab[i], modeTab[i]});
            chk(status[4:0], modeTab[i]);
            if (modeTab[i] === exc_pkg::MODE_ABT) begin
                chk(abtLink, instrAddr + ((vecTab[i] === exc_pkg::VEC_DABT) ? 32'h8 : 32'h4));
                chk(abtSaved, a);
            end
            a = {24'h00_0000, 3'h6, modeTab[i]};
        end
        // A 32-bit program space (cfg bit 3) silences the address exception.
        @(posedge clk);
        cfgWe <= 1'b1;
        cfgIn <= 8'h08;
        @(posedge clk);
        cfgWe <= 1'b0;
        fire(5'h01);
        chk(entryValid, 1'b0);
        // Fast interrupt unmasked, then masked by its own entry.
        wr_status(32'h0000_0013);
        fiqReq <= 1'b1;
        take_irq(exc_pkg::VEC_FIQ, exc_pkg::MODE_FIQ);
        chk(status[7:6], 2'h3);
        fire(5'h00);
        chk(entryValid, 1'b0);
        // Both pins low: fast wins; then normal alone.
        wr_status(32'h0000_0013);
        irqReq <= 1'b1;
        take_irq(exc_pkg::VEC_FIQ, exc_pkg::MODE_FIQ);
        fiqReq <= 1'b0;
        wr_status(32'h0000_0013);
        take_irq(exc_pkg::VEC_IRQ, exc_pkg::MODE_IRQ);
        chk(status[7:6], 2'h2);
        irqReq <= 1'b0;
        // Data abort with an unmasked fast interrupt chains straight into the fast vector.
        wr_status(32'h0000_0013);
        fiqReq <= 1'b1;
        repeat (3) @(posedge clk);
        fire(5'h10);
        chk(entry, {exc_pkg::VEC_DABT, exc_pkg::MODE_ABT});
        @(posedge clk);
        #1;
        chk(entryValid, 1'b1);
        chk(entry, {exc_pkg::VEC_FIQ, exc_pkg::MODE_FIQ});
        fiqReq <= 1'b0;
        // Reset pin in mid-run: idle addresses climb by a word, then the entry.
        wr_status(32'h0000_0010);
        rstReq <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk(busIdle, 1'b1);
        a = busAddr;
        @(posedge clk);
        rstReq <= 1'b0;
        #1;
        chk(busAddr, a + 32'h4);
        wait_reset_entry();
        chk(svcSaved, 32'h0000_0010);
        report_and_stop();
    end
endmodule
`default_nettype wire
